//--- iwc_params.svh
`ifndef IWC_PARAMS_SVH
`define IWC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ----------------------------------------------------------------------
`define IWC_OFS_LINE_EN     8'h00
`define IWC_OFS_REQ_FLAG    8'h04
`define IWC_OFS_EDGE_SEL    8'h08
`define IWC_OFS_CONTROL     8'h0c
`define IWC_OFS_STACK_PTR   8'h10
`define IWC_OFS_STATUS      8'h14

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define IWC_CTL_GIE_BIT     0
`define IWC_CTL_FAST_BIT    5
`define IWC_EDGE_RESET      14'h1555
`define IWC_STACK_RESET     8'h00

// ----------------------------------------------------------------------
// Vector, edge codes and timing counts
// ----------------------------------------------------------------------
`define IWC_VECTOR_ADDR     16'h0010
`define IWC_EDGE_RISE       2'h1
`define IWC_EDGE_FALL       2'h2
`define IWC_EDGE_BOTH       2'h3
`define IWC_WAKE_NORMAL     12'hbb8
`define IWC_WAKE_FAST       12'h02d
`define IWC_LRC_DIV         16'h0800
`define IWC_EXT_LINES       2

`endif

//--- iwc_pkg.sv
package iwc_pkg;

   // Sequencer states of the controller
   typedef enum logic [2:0] {
      IWC_IDLE,
      IWC_PUSH,
      IWC_POP,
      IWC_SLEEP,
      IWC_WAKE
   } iwc_state_type;

endpackage

//--- iwc_controller.sv
`timescale 1ns/100ps
`include "iwc_params.svh"
// Overview of operation
// - Seven independent interrupt request lines
// - Per-line enable gates each line
// - Hardware sets flags; software clears by writing
// - Edge select: rising, falling or both
// - Global enable, set and cleared by instructions
// - Accept: push PC, pointer+2, disable, vector 0x010
// - Return: pop PC, pointer-2, re-enable, resume
// - Flags set even when line disabled
// - Request flags readable to identify source
// - Save and restore accumulator and flags on stack
// - Three states: on, power-save, power-down
// - Power-save gates system clock, memory off
// - Timers stop in power-save when clock-dependent
// - Power-save wakes on pin, timer, comparator
// - Power-down stops oscillators; pin toggle wakes
// - Pin wake continues program without reset
// - Wake delay 3000 or 45 slow clocks
// - Fast boot option forces fast wake delay
module iwc_controller
   import iwc_pkg::*;
#(
   parameter logic [15:0] LRC_DIV = `IWC_LRC_DIV   // System clocks per slow RC tick
)(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [6:0]  irq_source,
   input  wire logic        int_ack,
   input  wire logic [15:0] ret_pc,
   input  wire logic        engint_cmd,
   input  wire logic        disgint_cmd,
   input  wire logic        reti_cmd,
   input  wire logic        pushaf_cmd,
   input  wire logic        popaf_cmd,
   input  wire logic        stopexe_cmd,
   input  wire logic        stopsys_cmd,
   input  wire logic [7:0]  acc_in,
   input  wire logic [7:0]  flag_in,
   output logic             int_request,
   output logic             vector_valid,
   output logic             pc_valid,
   output logic      [15:0] pc_out,
   output logic             af_valid,
   output logic      [7:0]  acc_out,
   output logic      [7:0]  flag_out,
   output logic             mem_we,
   output logic             mem_re,
   output logic      [7:0]  mem_addr,
   output logic      [7:0]  mem_wdata,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic [7:0]  port_pin_in,
   input  wire logic [7:0]  port_digital_input_enable,
   input  wire logic [7:0]  port_direction_reg,
   input  wire logic        timer_match,
   input  wire logic        timer_on_sysclk,
   input  wire logic        timer_osc_on,
   input  wire logic        cmp_event,
   input  wire logic        comparator_control_reg_7,
   input  wire logic        comparator_select_reg_6,
   input  wire logic        fast_boot_opt,
   output logic             sysclk_en,
   output logic             prog_mem_on,
   output logic             osc_on,
   output logic             timer_run,
   output logic             wake_done
);

   // -------------------------------------------------------------------
   // State record
   // -------------------------------------------------------------------
   typedef struct packed {
      iwc_state_type state;      // Sequencer state
      logic [1:0]  step;         // Step inside pop
      logic        is_af;        // Stack op moves acc and flags
      logic        down;         // Sleep is power-down
      logic [6:0]  src_s1;       // Sync stage one
      logic [6:0]  src_s2;       // Sync stage two
      logic [6:0]  src_prev;     // Previous level for edges
      logic [7:0]  pin_s1;       // Pin sync stage one
      logic [7:0]  pin_s2;       // Pin sync stage two
      logic [7:0]  pin_prev;     // Previous pin level
      logic [6:0]  flags;        // Request flags
      logic [6:0]  line_en;      // Per-line enables
      logic [13:0] edge_sel;     // Two bits per line
      logic        gie;          // Global enable
      logic        wake_fast;    // Fast wake mode bit
      logic [7:0]  stack_pointer; // Stack pointer
      logic [15:0] lrc_cnt;      // Slow clock divider
      logic        lrc_tick;     // Slow clock enable
      logic [11:0] wake_cnt;     // Slow ticks since wake
      logic [15:0] hold;         // Data in transit
      logic        waitreq;
      logic [31:0] rdata;
      logic        int_req;
      logic        mem_we;
      logic        mem_re;
      logic [7:0]  mem_addr;
      logic [7:0]  mem_wdata;
      logic        vec_valid;
      logic        pc_valid;
      logic [15:0] pc_out;
      logic        af_valid;
      logic [7:0]  acc_out;
      logic [7:0]  flag_out;
      logic        sysclk_en;
      logic        prog_mem_on;
      logic        osc_on;
      logic        timer_run;
      logic        wake_done;
   } iwc_regs_type;

   iwc_regs_type state_reg;      // Registered state
   iwc_regs_type state_next;     // Next state

   // -------------------------------------------------------------------
   // Per-line edge detection
   // -------------------------------------------------------------------
   logic [6:0]  line_level;      // Level seen by edge logic
   logic [6:0]  set_vec;         // Hardware set events
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_line
         logic rise;
         logic fall;
         logic [1:0] sel;
         // External pins are synchronised, internal sources are not
         assign line_level[gi] = (gi < `IWC_EXT_LINES) ? state_reg.src_s2[gi]
                                                       : irq_source[gi];
         assign rise = line_level[gi] & ~state_reg.src_prev[gi];
         assign fall = ~line_level[gi] & state_reg.src_prev[gi];
         assign sel  = state_reg.edge_sel[2*gi +: 2];
         // Edge choice per line; enable not involved
         assign set_vec[gi] = (rise && sel[0]) || (fall && sel[1]);
      end
   endgenerate

   // -------------------------------------------------------------------
   // Shared combinational terms
   // -------------------------------------------------------------------
   logic        bus_req;         // Any bus request
   logic        bus_done;        // Request completes this edge
   logic [11:0] wake_limit;      // Selected delay in slow ticks
   logic        pin_toggle;      // Digital-input pin changed
   logic        wake_evt;        // Any wake source for this sleep
   logic        idle;            // Core running, no stack op

   assign bus_req    = avs_read || avs_write;
   assign bus_done   = bus_req && !state_reg.waitreq;
   // Fast boot overrides the mode bit
   assign wake_limit = (fast_boot_opt || state_reg.wake_fast) ? `IWC_WAKE_FAST
                                                              : `IWC_WAKE_NORMAL;
   assign pin_toggle = |((state_reg.pin_s2 ^ state_reg.pin_prev)
                         & port_digital_input_enable & port_direction_reg);
   // Timer and comparator only wake power-save
   assign wake_evt   = pin_toggle
                     || (!state_reg.down && timer_match && !timer_on_sysclk)
                     || (!state_reg.down && cmp_event
                         && comparator_control_reg_7 && comparator_select_reg_6);
   assign idle       = state_reg.state == IWC_IDLE;

   // -------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      // Pulses default low
      state_next.vec_valid = 1'b0;
      state_next.pc_valid  = 1'b0;
      state_next.af_valid  = 1'b0;
      state_next.wake_done = 1'b0;
      state_next.mem_we    = 1'b0;
      state_next.mem_re    = 1'b0;
      state_next.lrc_tick  = 1'b0;
      // Synchronisers and previous levels
      state_next.src_s1   = irq_source;
      state_next.src_s2   = state_reg.src_s1;
      state_next.src_prev = line_level;
      state_next.pin_s1   = port_pin_in;
      state_next.pin_s2   = state_reg.pin_s1;
      state_next.pin_prev = state_reg.pin_s2;

      // Slow clock divider, held at zero while oscillators are off
      if (!state_reg.osc_on) begin
         state_next.lrc_cnt = 16'h0000;
      end else if (state_reg.lrc_cnt >= LRC_DIV - 16'h0001) begin
         state_next.lrc_cnt  = 16'h0000;
         state_next.lrc_tick = 1'b1;
      end else begin
         state_next.lrc_cnt = state_reg.lrc_cnt + 16'h0001;
      end

      // Avalon slave: one wait cycle, then answer
      state_next.waitreq = !(bus_req && state_reg.waitreq);
      if (bus_req && state_reg.waitreq) begin
         unique case (avs_address)
            `IWC_OFS_LINE_EN:   state_next.rdata = {25'h0, state_reg.line_en};
            // Source identification by reading flags
            `IWC_OFS_REQ_FLAG:  state_next.rdata = {25'h0, state_reg.flags};
            `IWC_OFS_EDGE_SEL:  state_next.rdata = {18'h0, state_reg.edge_sel};
            `IWC_OFS_CONTROL:   state_next.rdata = {26'h0, state_reg.wake_fast,
                                                    4'h0, state_reg.gie};
            `IWC_OFS_STACK_PTR: state_next.rdata = {24'h0, state_reg.stack_pointer};
            `IWC_OFS_STATUS:    state_next.rdata = {27'h0, state_reg.int_req,
                                                    state_reg.down,
                                                    3'(state_reg.state)};
            default:            state_next.rdata = 32'h0000_0000;
         endcase
      end
      // Register writes take effect on the completing edge
      if (bus_done && avs_write) begin
         unique case (avs_address)
            `IWC_OFS_LINE_EN:   state_next.line_en = avs_writedata[6:0];
            // Writing zero clears a flag; ones leave it
            `IWC_OFS_REQ_FLAG:  state_next.flags = state_reg.flags & avs_writedata[6:0];
            `IWC_OFS_EDGE_SEL:  state_next.edge_sel = avs_writedata[13:0];
            `IWC_OFS_CONTROL: begin
               state_next.gie       = avs_writedata[`IWC_CTL_GIE_BIT];
               state_next.wake_fast = avs_writedata[`IWC_CTL_FAST_BIT];
            end
            `IWC_OFS_STACK_PTR: state_next.stack_pointer = avs_writedata[7:0];
            default: ;
         endcase
      end
      // Hardware set wins over a clearing write
      state_next.flags = state_next.flags | set_vec;

      // Sequencer
      unique case (state_reg.state)
         IWC_IDLE: begin
            if (engint_cmd) begin
               state_next.gie = 1'b1;
            end else if (disgint_cmd) begin
               state_next.gie = 1'b0;
            end
            if (int_ack && state_reg.int_req) begin
               // Low byte of return address at the pointer
               state_next.gie       = 1'b0;
               state_next.hold      = ret_pc;
               state_next.mem_we    = 1'b1;
               state_next.mem_addr  = state_reg.stack_pointer;
               state_next.mem_wdata = ret_pc[7:0];
               state_next.is_af     = 1'b0;
               state_next.state     = IWC_PUSH;
            end else if (pushaf_cmd) begin
               // Accumulator then flags onto the stack
               state_next.hold      = {flag_in, acc_in};
               state_next.mem_we    = 1'b1;
               state_next.mem_addr  = state_reg.stack_pointer;
               state_next.mem_wdata = acc_in;
               state_next.is_af     = 1'b1;
               state_next.state     = IWC_PUSH;
            end else if (reti_cmd || popaf_cmd) begin
               // Pop reads the two bytes below the pointer
               state_next.mem_re   = 1'b1;
               state_next.mem_addr = state_reg.stack_pointer - 8'h02;
               state_next.is_af    = popaf_cmd && !reti_cmd;
               state_next.step     = 2'h0;
               state_next.state    = IWC_POP;
            end else if (stopexe_cmd || stopsys_cmd) begin
               // Halt core and switch off program memory
               state_next.sysclk_en   = 1'b0;
               state_next.prog_mem_on = 1'b0;
               state_next.down        = stopsys_cmd;
               // Power-down stops every oscillator
               state_next.osc_on      = !stopsys_cmd;
               // Timers keep running only on their own live clock
               state_next.timer_run   = !stopsys_cmd && !timer_on_sysclk
                                        && timer_osc_on;
               state_next.state       = IWC_SLEEP;
            end
         end
         IWC_PUSH: begin
            // High byte above the pointer, which then advances by two
            state_next.mem_we    = 1'b1;
            state_next.mem_addr  = state_reg.stack_pointer + 8'h01;
            state_next.mem_wdata = state_reg.hold[15:8];
            state_next.stack_pointer = state_reg.stack_pointer + 8'h02;
            state_next.state     = IWC_IDLE;
            if (state_reg.is_af) begin
               state_next.af_valid = 1'b1;
            end else begin
               // Next fetch from the fixed vector
               state_next.vec_valid = 1'b1;
               state_next.pc_out    = `IWC_VECTOR_ADDR;
            end
         end
         IWC_POP: begin
            unique case (state_reg.step)
               2'h0: begin
                  state_next.mem_re   = 1'b1;
                  state_next.mem_addr = state_reg.stack_pointer - 8'h01;
                  state_next.step     = 2'h1;
               end
               2'h1: begin
                  state_next.hold[7:0] = mem_rdata;
                  state_next.step      = 2'h2;
               end
               default: begin
                  state_next.stack_pointer = state_reg.stack_pointer - 8'h02;
                  state_next.state = IWC_IDLE;
                  state_next.step  = 2'h0;
                  if (state_reg.is_af) begin
                     state_next.acc_out  = state_reg.hold[7:0];
                     state_next.flag_out = mem_rdata;
                     state_next.af_valid = 1'b1;
                  end else begin
                     // Resume the interrupted stream, enable back on
                     state_next.pc_out   = {mem_rdata, state_reg.hold[7:0]};
                     state_next.pc_valid = 1'b1;
                     state_next.gie      = 1'b1;
                  end
               end
            endcase
         end
         IWC_SLEEP: begin
            if (wake_evt) begin
               // Restart the slow oscillator and count the delay
               state_next.osc_on   = 1'b1;
               state_next.wake_cnt = 12'h000;
               state_next.state    = IWC_WAKE;
            end
         end
         IWC_WAKE: begin
            if (state_reg.lrc_tick) begin
               if (state_reg.wake_cnt >= wake_limit - 12'h001) begin
                  // Clock back, core continues after the sleep
                  state_next.sysclk_en   = 1'b1;
                  state_next.prog_mem_on = 1'b1;
                  state_next.timer_run   = 1'b1;
                  state_next.down        = 1'b0;
                  state_next.wake_done   = 1'b1;
                  state_next.state       = IWC_IDLE;
               end else begin
                  state_next.wake_cnt = state_reg.wake_cnt + 12'h001;
               end
            end
         end
      endcase

      // Request to core: flag and enable and global enable
      state_next.int_req = state_next.gie && |(state_next.flags & state_next.line_en)
                           && state_next.state == IWC_IDLE;
   end

   // -------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_reg             <= '0;
         state_reg.state       <= IWC_IDLE;
         state_reg.edge_sel    <= `IWC_EDGE_RESET;
         state_reg.stack_pointer <= `IWC_STACK_RESET;
         state_reg.waitreq     <= 1'b1;
         state_reg.sysclk_en   <= 1'b1;
         state_reg.prog_mem_on <= 1'b1;
         state_reg.osc_on      <= 1'b1;
         state_reg.timer_run   <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // -------------------------------------------------------------------
   // Outputs straight from flip-flops
   // -------------------------------------------------------------------
   assign avs_readdata    = state_reg.rdata;
   assign avs_waitrequest = state_reg.waitreq;
   assign int_request     = state_reg.int_req;
   assign vector_valid    = state_reg.vec_valid;
   assign pc_valid        = state_reg.pc_valid;
   assign pc_out          = state_reg.pc_out;
   assign af_valid        = state_reg.af_valid;
   assign acc_out         = state_reg.acc_out;
   assign flag_out        = state_reg.flag_out;
   assign mem_we          = state_reg.mem_we;
   assign mem_re          = state_reg.mem_re;
   assign mem_addr        = state_reg.mem_addr;
   assign mem_wdata       = state_reg.mem_wdata;
   assign sysclk_en       = state_reg.sysclk_en;
   assign prog_mem_on     = state_reg.prog_mem_on;
   assign osc_on          = state_reg.osc_on;
   assign timer_run       = state_reg.timer_run;
   assign wake_done       = state_reg.wake_done;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   accept_push_a: assert property ((idle && int_ack && int_request)
      |=> (mem_we && mem_addr == $past(state_reg.stack_pointer) && !state_reg.gie)
      ##1 (vector_valid && pc_out == `IWC_VECTOR_ADDR
           && state_reg.stack_pointer == $past(state_reg.stack_pointer, 2) + 8'h02))
      else $error("interrupt entry sequence wrong");
   return_pop_a: assert property ((idle && reti_cmd && !pushaf_cmd
      && !(int_ack && int_request))
      |-> ##4 (pc_valid && state_reg.gie
               && state_reg.stack_pointer == $past(state_reg.stack_pointer, 4) - 8'h02))
      else $error("return sequence wrong");
   flag_set_a: assert property ((set_vec != 7'h00)
      |=> ((state_reg.flags & $past(set_vec)) == $past(set_vec)))
      else $error("hardware flag set lost");
   req_gating_a: assert property (int_request
      |-> idle && state_reg.gie && (state_reg.flags & state_reg.line_en) != 7'h00)
      else $error("request without enable");
   sleep_gate_a: assert property ((idle && stopexe_cmd && !pushaf_cmd
      && !reti_cmd && !popaf_cmd && !(int_ack && int_request))
      |=> (!sysclk_en && !prog_mem_on && osc_on) [*2])
      else $error("power-save gating wrong");
   down_osc_a: assert property ((state_reg.state == IWC_SLEEP && state_reg.down)
      |-> !osc_on && !timer_run)
      else $error("power-down left oscillator on");
   wake_count_a: assert property (wake_done
      |-> $past(state_reg.wake_cnt) == $past(wake_limit) - 12'h001)
      else $error("wake delay count wrong");
   fast_boot_a: assert property ((state_reg.state == IWC_WAKE && fast_boot_opt)
      |-> state_reg.wake_cnt < `IWC_WAKE_FAST)
      else $error("fast boot not forced");
   bus_answer_a: assert property ((bus_req && avs_waitrequest)
      |=> !avs_waitrequest)
      else $error("bus answer late");

endmodule

//--- iwc_core_model.sv
`timescale 1ns/100ps
// ------
// Core data memory holding the stack
// ------
module iwc_core_model (
   input  wire logic       ref_clk,
   input  wire logic       mem_we,
   input  wire logic       mem_re,
   input  wire logic [7:0] mem_addr,
   input  wire logic [7:0] mem_wdata,
   output logic      [7:0] mem_rdata
);
   logic [7:0] ram [256]; // Shared data and stack bytes
   initial mem_rdata = 8'h00;
   // Data one cycle after strobe; idle bus toggles so stale data is never valid
   always @(posedge ref_clk) begin
      if (mem_we) ram[mem_addr] <= mem_wdata;
      mem_rdata <= mem_re ? ram[mem_addr] : ~mem_rdata;
   end
endmodule

//--- interrupt_and_wakeup_control_tb.sv
`timescale 1ns/100ps
module interrupt_and_wakeup_control_tb;
   localparam int LRC = 4; // Short slow tick keeps the run brief
   logic ref_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
   logic [7:0] avs_address = '0, cmd = '0, acc_in = '0, flag_in = '0, port_pin_in = '0;
   logic [7:0] port_digital_input_enable = 8'h01, port_direction_reg = 8'h01;
   logic [7:0] acc_out, flag_out, mem_addr, mem_wdata, mem_rdata;
   logic [31:0] avs_writedata = '0, avs_readdata, q, r, rs = 32'h5e39038a;
   logic [6:0] irq_source = '0;
   logic [15:0] ret_pc = '0, pc_out;
   logic int_request, vector_valid, pc_valid, af_valid, mem_we, mem_re, sysclk_en;
   logic timer_match = 0, timer_on_sysclk = 0, timer_osc_on = 0, cmp_event = 0;
   logic comparator_control_reg_7 = 0, comparator_select_reg_6 = 0, fast_boot_opt = 0;
   logic prog_mem_on, osc_on, timer_run, wake_done;
   int err_total = 0, n_checks = 0, cyc = 0, t, n, exp_stack;
   int stk[$]; // Expected stack contents
   iwc_controller #(.LRC_DIV(16'h0004)) iwc_controller_i (.ref_clk, .reset_n,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .irq_source, .int_ack(cmd[7]), .ret_pc, .engint_cmd(cmd[0]),
      .disgint_cmd(cmd[1]), .reti_cmd(cmd[2]), .pushaf_cmd(cmd[3]), .popaf_cmd(cmd[4]),
      .stopexe_cmd(cmd[5]), .stopsys_cmd(cmd[6]), .acc_in, .flag_in, .int_request,
      .vector_valid, .pc_valid, .pc_out, .af_valid, .acc_out, .flag_out, .mem_we,
      .mem_re, .mem_addr, .mem_wdata, .mem_rdata, .port_pin_in, .port_direction_reg,
      .port_digital_input_enable, .timer_match, .timer_on_sysclk, .timer_osc_on,
      .cmp_event, .comparator_control_reg_7, .comparator_select_reg_6, .fast_boot_opt,
      .sysclk_en, .prog_mem_on, .osc_on, .timer_run, .wake_done);
   iwc_core_model iwc_core_model_i (.ref_clk, .mem_we, .mem_re, .mem_addr,
      .mem_wdata, .mem_rdata);
   always #4 ref_clk = ~ref_clk;
   // Hang guard
   always @(posedge ref_clk) if (++cyc == 40000) begin
      err_total++;
      end_sim();
   end
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Avalon access held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
      bus(1'b0, a, '0);
      chk(nm, e, q);
   endtask
   task automatic pulse(input int k);
      @(posedge ref_clk);
      cmd[k] <= 1'b1;
      @(posedge ref_clk);
      cmd[k] <= 1'b0;
   endtask
   task automatic wt();
      for (t = 0; t < 9 && (vector_valid | pc_valid | af_valid) !== 1'b1; t++) @(posedge ref_clk);
   endtask
   // Sleep, wake by source s, measure delay against d
   task automatic slp(input int k, input logic f, input logic o, input int s, input int d);
      r = xs();
      bus(1'b1, 8'h0c, {f, 5'h00});
      fast_boot_opt <= o;
      timer_osc_on <= r[0];
      timer_on_sysclk <= r[1] & (s != 1);
      {comparator_control_reg_7, comparator_select_reg_6} <= {2{s == 2}};
      pulse(k);
      repeat (3) @(posedge ref_clk);
      chk("sysclk", 0, {prog_mem_on, sysclk_en});
      chk("osc", k == 5, osc_on);
      chk("tmr", k == 5 && timer_osc_on && !timer_on_sysclk, timer_run);
      timer_match <= (s == 1);
      cmp_event <= (s == 2);
      port_pin_in[1:0] <= port_pin_in[1:0] ^ {s == 1, s == 0}; // Pin 1 lacks input enable
      @(posedge ref_clk);
      {timer_match, cmp_event} <= 2'h0;
      if (k == 6 && s != 0) begin
         repeat (30) @(posedge ref_clk);
         chk("asleep", 0, sysclk_en);
         port_pin_in[0] <= ~port_pin_in[0];
      end
      for (n = 0; n < 20000 && wake_done !== 1'b1; n++) @(posedge ref_clk);
      @(posedge ref_clk);
      chk("delay", 1, n >= d - LRC && n <= d + 6 * LRC);
      chk("resume", 3, {sysclk_en, prog_mem_on});
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(8'h08, "edge0", 32'h1555);
      rd(8'h00, "en0", '0);
      rd(8'h20, "unmap", '0);
      for (int c = 1; c < 4; c++) begin
         bus(1'b1, 8'h08, c * 32'h11); // Pin line 0 and line 2 share the choice
         bus(1'b1, 8'h04, '0);
         {irq_source[2], irq_source[0]} <= 2'h3;
         repeat (4) @(posedge ref_clk);
         rd(8'h04, "rise", (c & 1) * 5);
         chk("noirq", 0, int_request);
         bus(1'b1, 8'h04, '0);
         {irq_source[2], irq_source[0]} <= 2'h0;
         repeat (4) @(posedge ref_clk);
         rd(8'h04, "fall", (c >> 1) * 5);
      end
      r = xs();
      exp_stack = r & 32'h7e; // Even start with room above it
      bus(1'b1, 8'h10, exp_stack);
      bus(1'b1, 8'h00, 32'h04);
      bus(1'b1, 8'h04, '0);
      pulse(1);
      rd(8'h0c, "gie0", 0);
      pulse(0);
      rd(8'h0c, "gie1", 1);
      irq_source[2] <= 1'b1;
      for (t = 0; t < 9 && int_request !== 1'b1; t++) @(posedge ref_clk);
      chk("irq", 1, int_request);
      rd(8'h04, "src", 32'h04);
      ret_pc <= r[31:16];
      stk.push_back(r[31:16]);
      pulse(7);
      wt();
      chk("vec", 32'h0010, pc_out);
      rd(8'h0c, "gie_ack", 0);
      rd(8'h10, "push", exp_stack + 2);
      bus(1'b1, 8'h04, '0);
      pulse(2);
      wt();
      chk("ret", stk.pop_back(), pc_out);
      rd(8'h10, "pop", exp_stack);
      rd(8'h0c, "gie_ret", 1);
      acc_in <= r[7:0];
      flag_in <= r[15:8];
      pulse(3);
      wt();
      pulse(4);
      wt();
      chk("af", r[15:0], {flag_out, acc_out});
      rd(8'h10, "af_pop", exp_stack);
      slp(5, 1'b1, 1'b0, 0, 45 * LRC);
      slp(6, 1'b0, 1'b1, 1, 45 * LRC);
      slp(5, 1'b0, 1'b0, 2, 3000 * LRC);
      slp(5, 1'b0, 1'b0, 1, 3000 * LRC);
      end_sim();
   end
endmodule
